/* File: core/jdv_link_ctrl.sv */
// cpu side of the link controller: response request, vector, data buffer
`timescale 1ns/10ps
module jdv_link_ctrl (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire jdv_pkg::jdv_evt_s evt,
    output jdv_pkg::jdv_cmd_s     cmd,
    output logic                  irq
);

    localparam int NS = jdv_pkg::NSRC;

    // apb decode; zero wait states, read data set up in setup cycle
    logic setup;
    logic access;
    logic mapped;
    logic ctrl_wr;
    logic data_wr;
    logic data_rd;
    logic vec_rd;
    logic stat_rd;

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == jdv_pkg::OFS_CTRL) ||
                    (paddr == jdv_pkg::OFS_VEC)  ||
                    (paddr == jdv_pkg::OFS_DATA) ||
                    (paddr == jdv_pkg::OFS_STAT);
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    assign ctrl_wr = access & pwrite & (paddr == jdv_pkg::OFS_CTRL);
    assign data_wr = access & pwrite & (paddr == jdv_pkg::OFS_DATA);
    assign data_rd = access & ~pwrite & (paddr == jdv_pkg::OFS_DATA);
    assign vec_rd  = access & ~pwrite & (paddr == jdv_pkg::OFS_VEC);
    assign stat_rd = access & ~pwrite & (paddr == jdv_pkg::OFS_STAT);

    // state registers
    jdv_pkg::jdv_tx_e tx_st_q;
    logic             mrq_q;
    logic             eodr_q;
    logic             eod_seen_q;
    logic             underrun_q;
    logic             armed_q;
    logic             extra_q;
    logic             disable_q;
    logic [7:0]       rx_shadow_q;
    logic [3:0]       shown_q;
    logic [31:0]      prdata_q;
    logic [NS-1:0]    pend_q;
    logic [NS-1:0]    src_set;
    logic [NS-1:0]    src_clr;
    logic [3:0]       vec_code;
    logic [31:0]      rd_val;

    // transmit buffer handshake
    logic       shadow_full;
    logic [7:0] shadow_data;
    logic       take;
    logic       tx_active;
    logic       eodr_set;
    logic       mrq_try;
    logic       underrun_ev;
    logic       arb_ev;
    logic       err_ev;

    assign tx_active = (tx_st_q != jdv_pkg::TX_IDLE);
    assign take      = (tx_st_q == jdv_pkg::TX_LOAD) & shadow_full &
                       evt.byte_taken;
    assign mrq_try   = ctrl_wr & pwdata[jdv_pkg::CTRL_MRQ];
    assign eodr_set  = ctrl_wr & pwdata[jdv_pkg::CTRL_EOD] & mrq_q;
    assign arb_ev    = tx_active & evt.arb_lost;
    assign err_ev    = tx_active & evt.bus_error;
    // no byte waiting when the shift register empties
    assign underrun_ev = ((tx_st_q == jdv_pkg::TX_RUN) &
                          evt.tx_byte_done & ~shadow_full & ~eodr_q) |
                         ((tx_st_q == jdv_pkg::TX_LOAD) & ~shadow_full);

    // cpu writes feed the shadow; engine takes it into the shift reg
    jdv_tx_buf #(
        .W (8)
    ) u_tx_buf (
        .sys_clk (sys_clk),
        .rst     (rst),
        .wr_en   (data_wr),
        .wr_data (pwdata[7:0]),
        .take    (take),
        .full    (shadow_full),
        .data    (shadow_data)
    );

    // eod received opens the response slot until end of frame
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eod_seen_q <= 1'b0;
        end else if (evt.eod_rx) begin
            eod_seen_q <= 1'b1;
        end else if (evt.eof_rx) begin
            eod_seen_q <= 1'b0;
        end
    end

    // response request; hardware clear wins over a late set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mrq_q <= 1'b0;
        end else if (tx_st_q == jdv_pkg::TX_EOD && evt.eod_sent) begin
            mrq_q <= 1'b0;
        end else if (err_ev || underrun_ev) begin
            mrq_q <= 1'b0;
        end else if (arb_ev) begin
            mrq_q <= 1'b0;
        end else if (mrq_try && !eod_seen_q) begin
            mrq_q <= 1'b1;
        end else if (ctrl_wr && !pwdata[jdv_pkg::CTRL_MRQ] &&
                     !tx_active) begin
            mrq_q <= 1'b0;
        end
    end

    // end-of-data request only meaningful while a response is pending
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eodr_q <= 1'b0;
        end else if (!mrq_q) begin
            eodr_q <= 1'b0;
        end else if (tx_st_q == jdv_pkg::TX_EOD && evt.eod_sent) begin
            eodr_q <= 1'b0;
        end else if (eodr_set) begin
            eodr_q <= 1'b1;
        end
    end

    // response sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_st_q <= jdv_pkg::TX_IDLE;
        end else if (err_ev || arb_ev || underrun_ev) begin
            tx_st_q <= jdv_pkg::TX_IDLE;
        end else begin
            case (tx_st_q)
                jdv_pkg::TX_IDLE: begin
                    if (mrq_q && evt.eod_rx) begin
                        tx_st_q <= jdv_pkg::TX_NORM;
                    end
                end
                jdv_pkg::TX_NORM: begin
                    if (evt.norm_done) begin
                        tx_st_q <= jdv_pkg::TX_LOAD;
                    end
                end
                jdv_pkg::TX_LOAD: begin
                    if (take) begin
                        tx_st_q <= jdv_pkg::TX_RUN;
                    end
                end
                jdv_pkg::TX_RUN: begin
                    if (evt.tx_byte_done) begin
                        if (shadow_full) begin
                            tx_st_q <= jdv_pkg::TX_LOAD;
                        end else if (eodr_q) begin
                            tx_st_q <= jdv_pkg::TX_EOD;
                        end
                    end
                end
                jdv_pkg::TX_EOD: begin
                    if (evt.eod_sent) begin
                        tx_st_q <= jdv_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= jdv_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // trailing ones after late arbitration loss or an underrun
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            extra_q <= 1'b0;
        end else begin
            extra_q <= (arb_ev & evt.arb_last2) |
                       underrun_ev;
        end
    end

    // transmitter shut off after an underrun or bus error; engine waits for ones first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            disable_q <= 1'b0;
        end else begin
            disable_q <= underrun_ev | err_ev;
        end
    end

    // sticky underrun; the set beats a clearing status read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            underrun_q <= 1'b0;
        end else if (underrun_ev) begin
            underrun_q <= 1'b1;
        end else if (stat_rd) begin
            underrun_q <= 1'b0;
        end
    end

    // every completed byte lands in the shadow, read or not
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_shadow_q <= 8'h00;
        end else if (evt.rx_byte || evt.ifr_byte) begin
            rx_shadow_q <= evt.rx_data;
        end
    end

    // event sources into the pending set
    always_comb begin
        src_set                     = '0;
        src_set[jdv_pkg::SRC_EOF]   = evt.eof_rx;
        src_set[jdv_pkg::SRC_RESPONSE_BYTE_RECEIVED] = evt.ifr_byte;
        src_set[jdv_pkg::SRC_RX_BUFFER_FULL]  = evt.rx_byte;
        src_set[jdv_pkg::SRC_TX_BUFFER_EMPTY]  =
            (tx_st_q == jdv_pkg::TX_RUN) & evt.tx_first_bit;
        src_set[jdv_pkg::SRC_ARB]   = evt.arb_lost;
        src_set[jdv_pkg::SRC_CRC]   = evt.crc_err;
        src_set[jdv_pkg::SRC_INV]   = evt.sym_invalid;
        src_set[jdv_pkg::SRC_WAKE]  = evt.wakeup;
    end

    // per source clear and sticky flag; set wins over clear
    for (genvar i = 0; i < NS; i++) begin : g_src
        if (jdv_pkg::DATA_SRC_MASK[i]) begin : g_data
            if (i == jdv_pkg::SRC_TX_BUFFER_EMPTY) begin : g_tx
                assign src_clr[i] = (armed_q & data_wr) |
                                    eodr_set;
            end else begin : g_rx
                assign src_clr[i] = armed_q & data_rd;
            end
        end else begin : g_plain
            assign src_clr[i] = vec_rd &&
                                (shown_q == 4'(i + 1));
        end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                pend_q[i] <= 1'b0;
            end else if (src_set[i]) begin
                pend_q[i] <= 1'b1;
            end else if (src_clr[i]) begin
                pend_q[i] <= 1'b0;
            end
        end
    end

    // highest pending source gives the code, re-evaluated each cycle
    jdv_vec_enc #(
        .NSRC (NS)
    ) u_vec_enc (
        .pend (pend_q),
        .code (vec_code)
    );

    // vector read of a data source arms the following data access
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else if (vec_rd && shown_q != 4'h0 &&
                     jdv_pkg::DATA_SRC_MASK[3'(shown_q - 4'h1)]) begin
            armed_q <= 1'b1;
        end else if (data_rd || data_wr) begin
            armed_q <= 1'b0;
        end
    end

    // read mux; reserved bits stay zero
    always_comb begin
        rd_val = jdv_pkg::RD_ZERO;
        case (paddr)
            jdv_pkg::OFS_CTRL: begin
                rd_val[jdv_pkg::CTRL_MRQ] = mrq_q;
                rd_val[jdv_pkg::CTRL_EOD] = eodr_q;
            end
            jdv_pkg::OFS_VEC: begin
                rd_val[jdv_pkg::VEC_LSB +: jdv_pkg::CODE_W] =
                    vec_code;
            end
            jdv_pkg::OFS_DATA: begin
                rd_val[7:0] = rx_shadow_q;
            end
            jdv_pkg::OFS_STAT: begin
                rd_val[jdv_pkg::STAT_TX_BUFFER_EMPTY]  = pend_q[jdv_pkg::SRC_TX_BUFFER_EMPTY];
                rd_val[jdv_pkg::STAT_RX_BUFFER_FULL]  = pend_q[jdv_pkg::SRC_RX_BUFFER_FULL];
                rd_val[jdv_pkg::STAT_UNDR]  = underrun_q;
                rd_val[jdv_pkg::STAT_RESPONSE_BYTE_RECEIVED] =
                    pend_q[jdv_pkg::SRC_RESPONSE_BYTE_RECEIVED];
                rd_val[jdv_pkg::STAT_EODS]  = eod_seen_q;
            end
            default: begin
                rd_val = jdv_pkg::RD_ZERO;
            end
        endcase
    end

    // capture in setup so the access phase sees stable data
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_q <= jdv_pkg::RD_ZERO;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_val;
        end
    end

    // remember the code software actually saw for its clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shown_q <= 4'h0;
        end else if (setup && !pwrite &&
                     paddr == jdv_pkg::OFS_VEC) begin
            shown_q <= vec_code;
        end
    end

    assign prdata = prdata_q;
    assign irq    = (vec_code != 4'h0);

    // engine commands; byte comes straight from the shadow flop
    always_comb begin
        cmd            = '0;
        cmd.send_norm  = (tx_st_q == jdv_pkg::TX_NORM);
        cmd.byte_valid = (tx_st_q == jdv_pkg::TX_LOAD) &
                         shadow_full;
        cmd.byte_data  = shadow_data;
        cmd.send_eod   = (tx_st_q == jdv_pkg::TX_EOD);
        cmd.extra_ones = extra_q;
        cmd.tx_disable = disable_q;
    end

    // checks beside the logic they guard
    a_req_after_eod: assert property (
        @(posedge sys_clk) disable iff (rst)
        mrq_try && eod_seen_q && !mrq_q |=> !mrq_q)
        else $error("request set after eod");

    a_arb_no_retry: assert property (
        @(posedge sys_clk) disable iff (rst)
        arb_ev |=> !mrq_q && tx_st_q == jdv_pkg::TX_IDLE
                   && !cmd.byte_valid)
        else $error("retry after arbitration loss");

    a_last_two_ones: assert property (
        @(posedge sys_clk) disable iff (rst)
        arb_ev && evt.arb_last2 |=> cmd.extra_ones)
        else $error("missing extra ones");

    a_eod_no_byte: assert property (
        @(posedge sys_clk) disable iff (rst)
        tx_st_q == jdv_pkg::TX_RUN && evt.tx_byte_done && eodr_q
        && !shadow_full && !err_ev && !arb_ev
        |=> cmd.send_eod && !cmd.byte_valid)
        else $error("eod not sent after last byte");

    a_tx_buffer_empty_first_bit: assert property (
        @(posedge sys_clk) disable iff (rst)
        tx_st_q == jdv_pkg::TX_RUN && evt.tx_first_bit
        |=> pend_q[jdv_pkg::SRC_TX_BUFFER_EMPTY])
        else $error("tx empty not set");

    a_rx_overwrite: assert property (
        @(posedge sys_clk) disable iff (rst)
        evt.rx_byte |=> rx_shadow_q == $past(evt.rx_data))
        else $error("rx shadow not updated");

    a_vec_plain_clr: assert property (
        @(posedge sys_clk) disable iff (rst)
        vec_rd && shown_q == 4'(jdv_pkg::SRC_CRC + 1)
        && !evt.crc_err |=> !pend_q[jdv_pkg::SRC_CRC])
        else $error("vector read did not clear");

    a_rx_buffer_full_needs_data: assert property (
        @(posedge sys_clk) disable iff (rst)
        pend_q[jdv_pkg::SRC_RX_BUFFER_FULL] && !data_rd
        |=> pend_q[jdv_pkg::SRC_RX_BUFFER_FULL])
        else $error("rx full cleared without data read");

    a_underrun_stop: assert property (
        @(posedge sys_clk) disable iff (rst)
        underrun_ev |=> underrun_q && !mrq_q && cmd.tx_disable
                        ##1 !cmd.tx_disable || underrun_ev)
        else $error("underrun not handled");

    a_irq_code: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(pend_q[jdv_pkg::SRC_WAKE]) |-> irq
        && vec_code == 4'(jdv_pkg::SRC_WAKE + 1))
        else $error("wakeup not top priority");

endmodule

/* File: core/jdv_pkg.sv */
// shared constants, event and command carriers for the link controller
package jdv_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_VEC  = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;

    // control register fields
    localparam int CTRL_MRQ = 0;
    localparam int CTRL_EOD = 1;

    // status register fields
    localparam int STAT_TX_BUFFER_EMPTY  = 0;
    localparam int STAT_RX_BUFFER_FULL  = 1;
    localparam int STAT_UNDR  = 2;
    localparam int STAT_RESPONSE_BYTE_RECEIVED = 3;
    localparam int STAT_EODS  = 4;

    // source code sits above two zero bits so codes read four apart
    localparam int VEC_LSB = 2;
    localparam int CODE_W  = 4;

    // pending source index; code is index plus one
    localparam int NSRC      = 8;
    localparam int SRC_EOF   = 0;
    localparam int SRC_RESPONSE_BYTE_RECEIVED = 1;
    localparam int SRC_RX_BUFFER_FULL  = 2;
    localparam int SRC_TX_BUFFER_EMPTY  = 3;
    localparam int SRC_ARB   = 4;
    localparam int SRC_CRC   = 5;
    localparam int SRC_INV   = 6;
    localparam int SRC_WAKE  = 7;

    // sources that clear through data register service; tx empty also clears on an eod request write
    localparam logic [NSRC-1:0] DATA_SRC_MASK = 8'h0E;

    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // one-cycle events from the symbol engine, same clock
    typedef struct packed {
        logic       eod_rx;
        logic       eof_rx;
        logic       ifr_byte;
        logic       rx_byte;
        logic [7:0] rx_data;
        logic       byte_taken;
        logic       tx_first_bit;
        logic       tx_byte_done;
        logic       norm_done;
        logic       eod_sent;
        logic       arb_lost;
        logic       arb_last2;
        logic       crc_err;
        logic       sym_invalid;
        logic       wakeup;
        logic       bus_error;
    } jdv_evt_s;

    // requests to the symbol engine
    typedef struct packed {
        logic       send_norm;
        logic       byte_valid;
        logic [7:0] byte_data;
        logic       send_eod;
        logic       extra_ones;
        logic       tx_disable;
    } jdv_cmd_s;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_NORM,
        TX_LOAD,
        TX_RUN,
        TX_EOD
    } jdv_tx_e;

endpackage

/* File: core/jdv_tx_buf.sv */
// transmit shadow register in front of the engine shift register
`timescale 1ns/10ps
module jdv_tx_buf #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         take,
    output logic              full,
    output logic      [W-1:0] data
);

    if (W < 1) begin : g_chk
        $error("jdv_tx_buf: W must be positive");
    end

    logic         full_q;
    logic [W-1:0] data_q;

    // a write in the take cycle refills, so full stays set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            full_q <= 1'b0;
        end else if (wr_en) begin
            full_q <= 1'b1;
        end else if (take) begin
            full_q <= 1'b0;
        end
    end

    // shadow byte held until overwritten
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            data_q <= '0;
        end else if (wr_en) begin
            data_q <= wr_data;
        end
    end

    assign full = full_q;
    assign data = data_q;

endmodule

/* File: core/jdv_vec_enc.sv */
// priority encoder from pending sources to the vector code
`timescale 1ns/10ps
module jdv_vec_enc #(
    parameter int NSRC = 8
) (
    input  wire logic [NSRC-1:0] pend,
    output logic      [3:0]      code
);

    // code must fit four bits with zero kept for none pending
    if (NSRC < 1 || NSRC > 15) begin : g_chk
        $error("jdv_vec_enc: NSRC out of range");
    end

    // higher index overrides, so the top pending source wins
    always_comb begin
        code = 4'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (pend[i]) begin
                code = 4'(i + 1);
            end
        end
    end

endmodule

/* File: verif/jdv_engine_model.sv */
// symbol engine stand-in answering the controller's commands
`timescale 1ns/10ps
module jdv_engine_model (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic [3:0]        gap,
    input  wire jdv_pkg::jdv_evt_s ext,
    input  wire jdv_pkg::jdv_cmd_s cmd,
    output jdv_pkg::jdv_evt_s      evt
);
    jdv_pkg::jdv_evt_s eng_q;
    logic [3:0]        cnt_q;
    logic [1:0]        ph_q;

    // bench events merged with engine answers
    assign evt = jdv_pkg::jdv_evt_s'(eng_q | ext);

    // at most one answer per gap plus one cycles, so slow and prompt engines both occur
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            eng_q <= '0;
            cnt_q <= 4'h0;
            ph_q  <= 2'h0;
        end else begin
            eng_q <= '0;
            if (ext.arb_lost || ext.bus_error || cmd.tx_disable) begin
                ph_q <= 2'h0; // lost bus: the byte is gone
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (ph_q != 2'h0) begin
                eng_q.tx_first_bit <= (ph_q == 2'h1);
                eng_q.tx_byte_done <= (ph_q == 2'h2);
                ph_q  <= (ph_q == 2'h1) ? 2'h2 : 2'h0;
                cnt_q <= gap;
            end else if (cmd.send_norm) begin
                eng_q.norm_done <= 1'b1;
                cnt_q <= gap;
            end else if (cmd.byte_valid) begin
                eng_q.byte_taken <= 1'b1;
                ph_q  <= 2'h1;
                cnt_q <= gap;
            end else if (cmd.send_eod) begin
                eng_q.eod_sent <= 1'b1;
                cnt_q <= gap;
            end
        end
    end
endmodule

/* File: verif/tb_jdv_link_ctrl.sv */
// self-checking bench for the link controller cpu side
`timescale 1ns/10ps
module tb_jdv_link_ctrl;
    typedef struct packed {
        jdv_pkg::jdv_evt_s ev;
        logic [7:0]        v1;
        logic [7:0]        v2;
    } jdv_row_s;
    localparam logic [7:0] A_CT = jdv_pkg::OFS_CTRL;
    localparam logic [7:0] A_VE = jdv_pkg::OFS_VEC;
    localparam logic [7:0] A_DA = jdv_pkg::OFS_DATA;
    logic              sys_clk = 1'b0, rst = 1'b1, psel = 1'b0;
    logic              penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic              irq, err;
    logic [7:0]        paddr = 8'h00, bd;
    logic [31:0]       pwdata = 32'h0, prdata, rd;
    logic [3:0]        gap = 4'h8;
    logic [4:0]        mon;
    jdv_pkg::jdv_evt_s ext = '0, evt;
    jdv_pkg::jdv_cmd_s cmd;
    int                num_errors = 0, checks = 0, n_tk = 0, n_x = 0, n_d = 0;
    // one row per source except tx empty: vector after first and second read
    jdv_row_s rows [7] = '{
        '{'{eof_rx: 1'b1, default: '0}, 8'h04, 8'h00},
        '{'{ifr_byte: 1'b1, rx_data: 8'h5C, default: '0}, 8'h08, 8'h08},
        '{'{rx_byte: 1'b1, rx_data: 8'hA3, default: '0}, 8'h0C, 8'h0C},
        '{'{arb_lost: 1'b1, default: '0}, 8'h14, 8'h00},
        '{'{crc_err: 1'b1, default: '0}, 8'h18, 8'h00},
        '{'{sym_invalid: 1'b1, default: '0}, 8'h1C, 8'h00},
        '{'{wakeup: 1'b1, default: '0}, 8'h20, 8'h00}
    };

    always #10 sys_clk = ~sys_clk;
    assign mon = {~cmd.send_eod, irq, cmd.send_eod, cmd.byte_valid,
                  cmd.send_norm};

    jdv_link_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .cmd(cmd), .irq(irq));
    jdv_engine_model u_eng (.sys_clk(sys_clk), .rst(rst), .gap(gap),
        .ext(ext), .cmd(cmd), .evt(evt));

    // bytes taken, extra ones and disables seen, sampled off the edge
    always @(negedge sys_clk) begin
        n_tk = n_tk + int'(evt.byte_taken === 1'b1);
        n_x  = n_x + int'(cmd.extra_ones === 1'b1);
        n_d  = n_d + int'(cmd.tx_disable === 1'b1);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle cycle, so a next call never re-drives psel in this step
        @(posedge sys_clk);
    endtask

    task automatic rdv(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic pulse(input jdv_pkg::jdv_evt_s e);
        ext <= e;
        @(posedge sys_clk);
        ext <= '0;
        @(posedge sys_clk);
    endtask

    task automatic see_irq(input logic e);
        @(negedge sys_clk);
        chk(32'(irq), 32'(e));
        @(posedge sys_clk);
    endtask

    // bounded wait on one monitored level, sampled mid-cycle
    task automatic wfor(input int i);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (mon[i] !== 1'b1 && n < 200) begin
            n++;
            @(negedge sys_clk);
        end
        bd = cmd.byte_data;
        chk(32'(mon[i]), 32'h1);
        @(posedge sys_clk);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles of the run
    initial begin
        repeat (4000) @(posedge sys_clk);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdv(A_CT, 32'h0);
        chk(32'(cmd), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        see_irq(1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            see_irq(1'b1);
            rdv(A_VE, 32'(rows[i].v1));
            rdv(A_VE, 32'(rows[i].v2));
            apb(1'b0, A_DA, 32'h0);
            if (rows[i].v2 != 8'h00) chk(rd, 32'(rows[i].ev.rx_data));
            rdv(A_VE, 32'h0);
        end
        $display("test sources done");
        pulse('{wakeup: 1'b1, eof_rx: 1'b1, default: '0});
        rdv(A_VE, 32'h20);
        rdv(A_VE, 32'h04);
        pulse('{rx_byte: 1'b1, rx_data: 8'h11, default: '0});
        pulse('{rx_byte: 1'b1, rx_data: 8'h22, default: '0});
        rdv(A_VE, 32'h0C);
        rdv(A_DA, 32'h22);
        $display("test priority done");
        // two-byte response closed by end of data, no crc byte
        apb(1'b1, A_DA, 32'h3C);
        apb(1'b1, A_CT, 32'h1);
        pulse('{eod_rx: 1'b1, default: '0});
        wfor(0);
        wfor(1);
        chk(32'(bd), 32'h3C);
        wfor(3);
        rdv(A_VE, 32'h10);
        apb(1'b1, A_DA, 32'h5A);
        see_irq(1'b0);
        wfor(1);
        chk(32'(bd), 32'h5A);
        wfor(3);
        rdv(A_VE, 32'h10);
        apb(1'b1, A_CT, 32'h3);
        see_irq(1'b0);
        wfor(2);
        wfor(4);
        rdv(A_CT, 32'h0);
        chk(32'(n_tk), 32'h2);
        apb(1'b1, A_CT, 32'h1);
        rdv(A_CT, 32'h0);
        $display("test response done");
        // slow engine, arbitration lost late in the byte
        gap <= 4'hC;
        pulse('{eof_rx: 1'b1, default: '0});
        rdv(A_VE, 32'h04);
        apb(1'b1, A_DA, 32'h77);
        apb(1'b1, A_CT, 32'h1);
        pulse('{eod_rx: 1'b1, default: '0});
        wfor(3);
        pulse('{arb_lost: 1'b1, arb_last2: 1'b1, default: '0});
        rdv(A_CT, 32'h0);
        chk(32'(n_x), 32'h1);
        rdv(A_VE, 32'h14);
        repeat (40) @(posedge sys_clk);
        chk(32'(n_tk), 32'h3);
        $display("test arbitration done");
        // empty shadow at load time: underrun, ones, transmitter off
        pulse('{eof_rx: 1'b1, default: '0});
        apb(1'b1, A_CT, 32'h1);
        pulse('{eod_rx: 1'b1, default: '0});
        repeat (6) @(posedge sys_clk);
        chk(32'(n_x), 32'h2);
        chk(32'(n_d), 32'h1);
        rdv(jdv_pkg::OFS_STAT, 32'h15);
        rdv(jdv_pkg::OFS_STAT, 32'h11);
        rdv(A_CT, 32'h0);
        // bus error while the byte waits drops the request
        pulse('{eof_rx: 1'b1, default: '0});
        apb(1'b1, A_DA, 32'h44);
        apb(1'b1, A_CT, 32'h1);
        pulse('{eod_rx: 1'b1, default: '0});
        wfor(1);
        pulse('{bus_error: 1'b1, default: '0});
        rdv(A_CT, 32'h0);
        chk(32'(n_d), 32'h2);
        $display("test abort done");
        close_out();
    end
endmodule
